// >>> design/mxov_regs.sv
// module: mixer gain and first output pair volume register bank, AXI4-Lite slave
//
// Functional notes
// - aux3 right record gain at bits 15:13
// - aux2 right record gain at bits 7:5
// - bit 0 selects right pga +20dB boost
// - bit 15 routes fourth output left/right
// - bits 3:1 set fourth output feedback gain
// - enable bit 15, mute bit 14, reset zero
// - bit 13 defers gain change to zero cross
// - update bit arms both channels; each applies at once or at its own zero cross
// - six-bit volume bits 7:2, resets 111001
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/10ps

module mxov_regs #(
   parameter int ADDR_W = 12
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic left_zero_cross_seen,
   input wire logic right_zero_cross_seen,
   output mxov_pkg::mxov_record_t record_ctrl,
   output mxov_pkg::mxov_feedback_t feedback_ctrl,
   output mxov_pkg::mxov_phones_t left_phones,
   output mxov_pkg::mxov_phones_t right_phones,
   output logic left_level_pending,
   output logic right_level_pending
);

   // ------------------------------------------------------------
   // parameter check
   // ------------------------------------------------------------
   if (ADDR_W < mxov_pkg::MIN_ADDR_W || ADDR_W > 32) begin : g_bad_addr_w
      $error("ADDR_W must lie between 9 and 32");
   end

   // ------------------------------------------------------------
   // write channel state
   // ------------------------------------------------------------
   logic aw_have_q, aw_have_d;
   logic w_have_q, w_have_d;
   logic [ADDR_W-1:0] aw_addr_q, aw_addr_d;
   logic [15:0] w_data_q, w_data_d;
   logic [1:0] w_strb_q, w_strb_d;
   logic bvalid_q, bvalid_d;
   logic [1:0] bresp_q, bresp_d;
   logic aw_take, w_take, do_write;
   logic [ADDR_W-1:0] wr_addr;
   logic [15:0] wr_data;
   logic [1:0] wr_strb;
   logic [15:0] lane_mask;

   // ------------------------------------------------------------
   // register state
   // ------------------------------------------------------------
   logic [15:0] record_q, record_d;
   logic [15:0] feedback_q, feedback_d;
   logic [15:0] left_q, left_d;
   logic [15:0] right_q, right_d;
   logic [5:0] left_applied_q, left_applied_d;
   logic [5:0] right_applied_q, right_applied_d;
   logic left_armed_q, left_armed_d;
   logic right_armed_q, right_armed_d;
   logic hit_record, hit_feedback, hit_left, hit_right, hit_any;
   logic update_req;

   // ------------------------------------------------------------
   // read channel state
   // ------------------------------------------------------------
   logic rvalid_q, rvalid_d;
   logic [31:0] rdata_q, rdata_d;
   logic [1:0] rresp_q, rresp_d;
   logic [15:0] rd_word;
   logic rd_hit;

   // ------------------------------------------------------------
   // write handshake: address and data in either order
   // ------------------------------------------------------------
   assign s_axi_awready = !aw_have_q && !bvalid_q;
   assign s_axi_wready = !w_have_q && !bvalid_q;
   assign aw_take = s_axi_awvalid && s_axi_awready;
   assign w_take = s_axi_wvalid && s_axi_wready;
   assign wr_addr = aw_have_q ? aw_addr_q : s_axi_awaddr;
   assign wr_data = w_have_q ? w_data_q : s_axi_wdata[15:0];
   assign wr_strb = w_have_q ? w_strb_q : s_axi_wstrb[1:0];
   assign do_write = (aw_have_q || aw_take) && (w_have_q || w_take) && !bvalid_q;
   assign lane_mask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};

   always_comb begin
      aw_have_d = aw_have_q;
      w_have_d = w_have_q;
      aw_addr_d = aw_addr_q;
      w_data_d = w_data_q;
      w_strb_d = w_strb_q;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      if (aw_take) begin
         aw_have_d = 1'b1;
         aw_addr_d = s_axi_awaddr;
      end
      if (w_take) begin
         w_have_d = 1'b1;
         w_data_d = s_axi_wdata[15:0];
         w_strb_d = s_axi_wstrb[1:0];
      end
      if (do_write) begin
         aw_have_d = 1'b0;
         w_have_d = 1'b0;
         bvalid_d = 1'b1;
         bresp_d = hit_any ? mxov_pkg::RESP_OKAY : mxov_pkg::RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
         bvalid_d = 1'b0;
      end
   end

   // ------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------
   assign hit_record = wr_addr == ADDR_W'(mxov_pkg::RIGHT_RECORD_ADDR);
   assign hit_feedback = wr_addr == ADDR_W'(mxov_pkg::AUX_FEEDBACK_ADDR);
   assign hit_left = wr_addr == ADDR_W'(mxov_pkg::LEFT_VOLUME_ADDR);
   assign hit_right = wr_addr == ADDR_W'(mxov_pkg::RIGHT_VOLUME_ADDR);
   assign hit_any = hit_record || hit_feedback || hit_left || hit_right;
   // a 1 written to the update bit of either channel
   assign update_req = do_write && (hit_left || hit_right) && wr_strb[1]
                       && wr_data[mxov_pkg::PH_UPDATE_BIT];

   // ------------------------------------------------------------
   // register writes
   // ------------------------------------------------------------
   function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] data,
                                         input logic [15:0] lanes, input logic [15:0] fmask);
      logic [15:0] m;
      m = lanes & fmask;
      merge = (old & ~m) | (data & m);
   endfunction

   always_comb begin
      record_d = record_q;
      feedback_d = feedback_q;
      left_d = left_q;
      right_d = right_q;
      if (do_write && hit_record) begin
         record_d = merge(record_q, wr_data, lane_mask, mxov_pkg::RECORD_MASK);
      end
      if (do_write && hit_feedback) begin
         feedback_d = merge(feedback_q, wr_data, lane_mask, mxov_pkg::FEEDBACK_MASK);
      end
      if (do_write && hit_left) begin
         left_d = merge(left_q, wr_data, lane_mask, mxov_pkg::PHONES_MASK);
      end
      if (do_write && hit_right) begin
         right_d = merge(right_q, wr_data, lane_mask, mxov_pkg::PHONES_MASK);
      end
   end

   // ------------------------------------------------------------
   // deferred volume apply
   // ------------------------------------------------------------
   always_comb begin
      left_armed_d = left_armed_q;
      right_armed_d = right_armed_q;
      left_applied_d = left_applied_q;
      right_applied_d = right_applied_q;
      // apply now, or wait for a zero crossing when enabled
      if (left_armed_q && (!left_phones.zero_cross || left_zero_cross_seen)) begin
         left_applied_d = left_q[mxov_pkg::PH_LEVEL_LSB +: mxov_pkg::LEVEL_W];
         left_armed_d = 1'b0;
      end
      if (right_armed_q && (!right_phones.zero_cross || right_zero_cross_seen)) begin
         right_applied_d = right_q[mxov_pkg::PH_LEVEL_LSB +: mxov_pkg::LEVEL_W];
         right_armed_d = 1'b0;
      end
      // a new update request wins over the apply in the same cycle
      if (update_req) begin
         left_armed_d = 1'b1;
         right_armed_d = 1'b1;
      end
   end

   // ------------------------------------------------------------
   // read path
   // ------------------------------------------------------------
   assign s_axi_arready = !rvalid_q;

   always_comb begin
      rd_word = 16'h0000;
      rd_hit = 1'b1;
      case (s_axi_araddr)
         ADDR_W'(mxov_pkg::RIGHT_RECORD_ADDR): begin
            rd_word = record_q;
         end
         ADDR_W'(mxov_pkg::AUX_FEEDBACK_ADDR): begin
            rd_word = feedback_q;
         end
         ADDR_W'(mxov_pkg::LEFT_VOLUME_ADDR): begin
            rd_word = left_q;
         end
         ADDR_W'(mxov_pkg::RIGHT_VOLUME_ADDR): begin
            rd_word = right_q;
         end
         default: begin
            rd_hit = 1'b0;
         end
      endcase
   end

   always_comb begin
      rvalid_d = rvalid_q;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      if (s_axi_arvalid && s_axi_arready) begin
         rvalid_d = 1'b1;
         rdata_d = {16'h0000, rd_word};
         rresp_d = rd_hit ? mxov_pkg::RESP_OKAY : mxov_pkg::RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_d = 1'b0;
      end
   end

   // ------------------------------------------------------------
   // state registers
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         aw_addr_q <= '0;
         w_data_q <= 16'h0000;
         w_strb_q <= 2'h0;
         bvalid_q <= 1'b0;
         bresp_q <= mxov_pkg::RESP_OKAY;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= mxov_pkg::RESP_OKAY;
         record_q <= mxov_pkg::RECORD_RESET;
         feedback_q <= mxov_pkg::FEEDBACK_RESET;
         left_q <= mxov_pkg::PHONES_RESET;
         right_q <= mxov_pkg::PHONES_RESET;
         left_applied_q <= mxov_pkg::LEVEL_RESET;
         right_applied_q <= mxov_pkg::LEVEL_RESET;
         left_armed_q <= 1'b0;
         right_armed_q <= 1'b0;
      end else begin
         aw_have_q <= aw_have_d;
         w_have_q <= w_have_d;
         aw_addr_q <= aw_addr_d;
         w_data_q <= w_data_d;
         w_strb_q <= w_strb_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         rvalid_q <= rvalid_d;
         rdata_q <= rdata_d;
         rresp_q <= rresp_d;
         record_q <= record_d;
         feedback_q <= feedback_d;
         left_q <= left_d;
         right_q <= right_d;
         left_applied_q <= left_applied_d;
         right_applied_q <= right_applied_d;
         left_armed_q <= left_armed_d;
         right_armed_q <= right_armed_d;
      end
   end

   // ------------------------------------------------------------
   // bus outputs
   // ------------------------------------------------------------
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

   // ------------------------------------------------------------
   // control outputs to the analog path
   // ------------------------------------------------------------
   assign record_ctrl.aux3_right_record_gain =
      record_q[mxov_pkg::AUX3_GAIN_LSB +: mxov_pkg::GAIN_W];
   assign record_ctrl.aux2_right_record_gain =
      record_q[mxov_pkg::AUX2_GAIN_LSB +: mxov_pkg::GAIN_W];
   assign record_ctrl.right_pga_boost = record_q[mxov_pkg::PGA_BOOST_BIT];
   assign feedback_ctrl.feedback_mixer_select = feedback_q[mxov_pkg::FB_SELECT_BIT];
   assign feedback_ctrl.feedback_mixer_gain =
      feedback_q[mxov_pkg::FB_GAIN_LSB +: mxov_pkg::GAIN_W];

   assign left_phones.enable = left_q[mxov_pkg::PH_ENABLE_BIT];
   assign left_phones.mute = left_q[mxov_pkg::PH_MUTE_BIT];
   assign left_phones.zero_cross = left_q[mxov_pkg::PH_ZC_BIT];
   // analog path sees only the applied level
   assign left_phones.level = left_applied_q;
   assign right_phones.enable = right_q[mxov_pkg::PH_ENABLE_BIT];
   assign right_phones.mute = right_q[mxov_pkg::PH_MUTE_BIT];
   assign right_phones.zero_cross = right_q[mxov_pkg::PH_ZC_BIT];
   assign right_phones.level = right_applied_q;

   assign left_level_pending = left_armed_q;
   assign right_level_pending = right_armed_q;

endmodule

// >>> design/mxov_pkg.sv
// package: register map, field layout and carrier types for the mixer/output register bank
package mxov_pkg;

   // ------------------------------------------------------------
   // register indices and byte addresses
   // ------------------------------------------------------------
   localparam logic [7:0] RIGHT_RECORD_MIXER_GAIN_IDX = 8'h63;
   localparam logic [7:0] AUX_FEEDBACK_MIXER_GAIN_IDX = 8'h64;
   localparam logic [7:0] FIRST_LEFT_OUTPUT_VOLUME_IDX = 8'h68;
   localparam logic [7:0] FIRST_RIGHT_OUTPUT_VOLUME_IDX = 8'h69;
   localparam int BYTES_PER_REG = 4;
   localparam int MIN_ADDR_W = 9;
   localparam logic [9:0] RIGHT_RECORD_ADDR = 10'(RIGHT_RECORD_MIXER_GAIN_IDX * BYTES_PER_REG);
   localparam logic [9:0] AUX_FEEDBACK_ADDR = 10'(AUX_FEEDBACK_MIXER_GAIN_IDX * BYTES_PER_REG);
   localparam logic [9:0] LEFT_VOLUME_ADDR = 10'(FIRST_LEFT_OUTPUT_VOLUME_IDX * BYTES_PER_REG);
   localparam logic [9:0] RIGHT_VOLUME_ADDR = 10'(FIRST_RIGHT_OUTPUT_VOLUME_IDX * BYTES_PER_REG);

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int AUX3_GAIN_LSB = 13;
   localparam int AUX2_GAIN_LSB = 5;
   localparam int PGA_BOOST_BIT = 0;
   localparam int FB_SELECT_BIT = 15;
   localparam int FB_GAIN_LSB = 1;
   localparam int PH_ENABLE_BIT = 15;
   localparam int PH_MUTE_BIT = 14;
   localparam int PH_ZC_BIT = 13;
   localparam int PH_UPDATE_BIT = 8;
   localparam int PH_LEVEL_LSB = 2;
   localparam int GAIN_W = 3;
   localparam int LEVEL_W = 6;

   // ------------------------------------------------------------
   // writable masks and reset values
   // ------------------------------------------------------------
   localparam logic [15:0] RECORD_MASK = 16'he0e1;
   localparam logic [15:0] FEEDBACK_MASK = 16'h800e;
   localparam logic [15:0] PHONES_MASK = 16'he1fc;
   localparam logic [15:0] RECORD_RESET = 16'h0000;
   localparam logic [15:0] FEEDBACK_RESET = 16'h0000;
   localparam logic [15:0] PHONES_RESET = 16'h00e4;
   localparam logic [5:0] LEVEL_RESET = 6'h39;

   // ------------------------------------------------------------
   // bus answer codes
   // ------------------------------------------------------------
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ------------------------------------------------------------
   // carrier types
   // ------------------------------------------------------------
   typedef struct packed {
      logic [2:0] aux3_right_record_gain;
      logic [2:0] aux2_right_record_gain;
      logic right_pga_boost;
   } mxov_record_t;

   typedef struct packed {
      logic feedback_mixer_select;
      logic [2:0] feedback_mixer_gain;
   } mxov_feedback_t;

   typedef struct packed {
      logic enable;
      logic mute;
      logic zero_cross;
      logic [5:0] level;
   } mxov_phones_t;

endpackage

// >>> dv/mxov_regs_assertions.sv
// checker: port-level properties of the mixer/output register bank
`timescale 1ns/10ps

module mxov_regs_assertions #(
   parameter int ADDR_W = 12
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic left_zero_cross_seen,
   input wire mxov_pkg::mxov_record_t record_ctrl,
   input wire mxov_pkg::mxov_feedback_t feedback_ctrl,
   input wire mxov_pkg::mxov_phones_t left_phones,
   input wire mxov_pkg::mxov_phones_t right_phones,
   input wire logic left_level_pending,
   input wire logic right_level_pending
);
   // ------------------------------------------------------------
   // write decode
   // ------------------------------------------------------------
   logic wr;
   logic to_rec;
   logic to_fb;
   logic to_left;
   logic to_vol;
   assign wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   assign to_rec = wr && (s_axi_awaddr == ADDR_W'(mxov_pkg::RIGHT_RECORD_ADDR));
   assign to_fb = wr && (s_axi_awaddr == ADDR_W'(mxov_pkg::AUX_FEEDBACK_ADDR));
   assign to_left = wr && (s_axi_awaddr == ADDR_W'(mxov_pkg::LEFT_VOLUME_ADDR));
   assign to_vol = to_left || (wr && (s_axi_awaddr == ADDR_W'(mxov_pkg::RIGHT_VOLUME_ADDR)));

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!resetn);

   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   a_aux3_gain: assert property (
      to_rec && s_axi_wstrb[1] |=> record_ctrl.aux3_right_record_gain == $past(s_axi_wdata[15:13]))
      else $error("aux3 gain not stored");
   a_aux2_gain: assert property (
      to_rec && s_axi_wstrb[0] |=> record_ctrl.aux2_right_record_gain == $past(s_axi_wdata[7:5]))
      else $error("aux2 gain not stored");
   a_pga_boost: assert property (
      to_rec && s_axi_wstrb[0] |=> record_ctrl.right_pga_boost == $past(s_axi_wdata[0]))
      else $error("boost bit not stored");
   a_fb_route: assert property (
      to_fb && s_axi_wstrb[1] |=> feedback_ctrl.feedback_mixer_select == $past(s_axi_wdata[15]))
      else $error("feedback route not stored");
   a_fb_gain: assert property (
      to_fb && s_axi_wstrb[0] |=> feedback_ctrl.feedback_mixer_gain == $past(s_axi_wdata[3:1]))
      else $error("feedback gain not stored");
   a_left_ctrl: assert property (
      to_left && s_axi_wstrb[1] |=> {left_phones.enable, left_phones.mute,
      left_phones.zero_cross} == $past(s_axi_wdata[15:13]))
      else $error("left control bits not stored");
   a_update_both: assert property (
      to_vol && s_axi_wstrb[1] && s_axi_wdata[8] |=> ##[0:1]
      (left_level_pending && right_level_pending))
      else $error("update did not mark both channels");
   a_instant_apply: assert property (
      right_level_pending && !right_phones.zero_cross && !wr |=> !right_level_pending)
      else $error("immediate level not applied");
   a_zc_hold: assert property (
      left_level_pending && left_phones.zero_cross && !left_zero_cross_seen |=> left_level_pending)
      else $error("level applied without zero crossing");
   a_level_hold: assert property (
      !left_level_pending |=> $stable(left_phones.level))
      else $error("left level moved without update");
   a_read_upper: assert property (
      s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
      else $error("upper read bits not zero");
endmodule

bind mxov_regs mxov_regs_assertions #(.ADDR_W(ADDR_W)) mxov_regs_assertions_inst (.*);

// >>> dv/tb.sv
// testbench: self-checking bench for the mixer/output register bank
`timescale 1ns/10ps

`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin failures++; \
   $display("wrong value at %0t: got %h expected %h", $time, g, e); end end

module tb;
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic left_zero_cross_seen = 1'b0, right_zero_cross_seen = 1'b0;
   mxov_pkg::mxov_record_t record_ctrl;
   mxov_pkg::mxov_feedback_t feedback_ctrl;
   mxov_pkg::mxov_phones_t left_phones, right_phones;
   logic left_level_pending, right_level_pending;
   int failures = 0, tests_run = 0, cycles = 0;
   integer seed = 32'h6d1d8aa5;
   logic [15:0] sh [4];
   logic [5:0] apl [2];
   logic [1:0] pnd;
   logic [31:0] d;
   logic [1:0] r;

   mxov_regs #(.ADDR_W(12)) mxov_regs_inst (.*);

   always #12.5 ref_clk = ~ref_clk;

   // ------------------------------------------------------------
   // closing and hang guard
   // ------------------------------------------------------------
   task automatic report_and_stop();
      $display("checks %0d, mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         report_and_stop();
      end
   end

   // ------------------------------------------------------------
   // bus tasks and expectations
   // ------------------------------------------------------------
   task automatic axi_write(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s,
      output logic [1:0] rs);
      logic ha, hw, hb;
      @(posedge ref_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(negedge ref_clk);
         ha = s_axi_awvalid && s_axi_awready;
         hw = s_axi_wvalid && s_axi_wready;
         hb = s_axi_bvalid;
         rs = s_axi_bresp;
         @(posedge ref_clk);
         if (ha) s_axi_awvalid <= 1'b0;
         if (hw) s_axi_wvalid <= 1'b0;
         if (hb) s_axi_bready <= 1'b0;
      end while (!hb);
   endtask

   task automatic axi_read(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
      logic ha, hr;
      @(posedge ref_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(negedge ref_clk);
         ha = s_axi_arvalid && s_axi_arready;
         hr = s_axi_rvalid;
         v = s_axi_rdata;
         rs = s_axi_rresp;
         @(posedge ref_clk);
         if (ha) s_axi_arvalid <= 1'b0;
         if (hr) s_axi_rready <= 1'b0;
      end while (!hr);
   endtask

   function automatic logic [11:0] reg_addr(input int i);
      case (i)
         0: return 12'(mxov_pkg::RIGHT_RECORD_ADDR);
         1: return 12'(mxov_pkg::AUX_FEEDBACK_ADDR);
         2: return 12'(mxov_pkg::LEFT_VOLUME_ADDR);
         default: return 12'(mxov_pkg::RIGHT_VOLUME_ADDR);
      endcase
   endfunction

   function automatic logic [15:0] reg_mask(input int i);
      return (i == 0) ? mxov_pkg::RECORD_MASK : (i == 1) ? mxov_pkg::FEEDBACK_MASK :
         mxov_pkg::PHONES_MASK;
   endfunction

   task automatic model_reset();
      sh[0] = 16'h0000;
      sh[1] = 16'h0000;
      sh[2] = 16'h00e4;
      sh[3] = 16'h00e4;
      apl[0] = 6'h39;
      apl[1] = 6'h39;
      pnd = 2'h0;
   endtask

   task automatic model_apply(input logic [1:0] seen);
      for (int c = 0; c < 2; c++) begin
         if (pnd[c] && (!sh[c + 2][13] || seen[c])) begin
            apl[c] = sh[c + 2][7:2];
            pnd[c] = 1'b0;
         end
      end
   endtask

   task automatic check_ports();
      @(negedge ref_clk);
      `CHK(record_ctrl, {sh[0][15:13], sh[0][7:5], sh[0][0]})
      `CHK(feedback_ctrl, {sh[1][15], sh[1][3:1]})
      `CHK(left_phones, {sh[2][15:13], apl[0]})
      `CHK(right_phones, {sh[3][15:13], apl[1]})
      `CHK({right_level_pending, left_level_pending}, pnd)
   endtask

   task automatic do_write(input int i, input logic [15:0] v, input logic [1:0] s);
      logic [15:0] m;
      m = reg_mask(i) & {{8{s[1]}}, {8{s[0]}}};
      sh[i] = (sh[i] & ~m) | (v & m);
      if (i >= 2 && s[1] && v[8]) pnd = 2'h3;
      model_apply(2'h0);
      axi_write(reg_addr(i), {16'h0, v}, {2'h0, s}, r);
      `CHK(r, mxov_pkg::RESP_OKAY)
      check_ports();
   endtask

   task automatic do_read(input int i);
      axi_read(reg_addr(i), d, r);
      `CHK(d, {16'h0, sh[i]})
      `CHK(r, mxov_pkg::RESP_OKAY)
   endtask

   task automatic pulse_zc(input logic lz, input logic rz);
      @(posedge ref_clk);
      left_zero_cross_seen <= lz;
      right_zero_cross_seen <= rz;
      @(posedge ref_clk);
      left_zero_cross_seen <= 1'b0;
      right_zero_cross_seen <= 1'b0;
      model_apply({rz, lz});
      check_ports();
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      int i;
      model_reset();
      repeat (8) @(posedge ref_clk);
      resetn <= 1'b1;
      for (i = 0; i < 4; i++) do_read(i);
      axi_write(12'h194, 32'hffff_ffff, 4'hf, r);
      `CHK(r, mxov_pkg::RESP_SLVERR)
      axi_read(12'h194, d, r);
      `CHK(d, 32'h0)
      `CHK(r, mxov_pkg::RESP_SLVERR)
      for (i = 0; i < 8; i++) begin
         do_write(0, {3'(i), 5'h1f, 3'(i), 4'hf, i[0]}, 2'h3);
         do_write(1, {i[0], 11'h7ff, 3'(i), 1'h1}, 2'h3);
      end
      for (i = 0; i < 40; i++) begin
         int k;
         k = $unsigned($random(seed)) % 4;
         do_write(k, 16'($random(seed)), 2'($random(seed)));
         do_read(k);
      end
      do_write(2, 16'h2054, 2'h3);
      do_write(3, 16'h00a8, 2'h3);
      pulse_zc(1'b1, 1'b1);
      `CHK({left_level_pending, right_level_pending}, 2'h0)
      do_write(3, 16'h01a8, 2'h3);
      repeat (3) @(negedge ref_clk);
      `CHK(right_level_pending, 1'b0)
      `CHK(left_level_pending, 1'b1)
      pulse_zc(1'b1, 1'b0);
      `CHK(left_level_pending, 1'b0)
      do_read(2);
      @(posedge ref_clk);
      resetn <= 1'b0;
      repeat (2) @(posedge ref_clk);
      resetn <= 1'b1;
      model_reset();
      check_ports();
      for (i = 0; i < 4; i++) do_read(i);
      report_and_stop();
   end
endmodule
